//--- logic/lpms_top.v
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "lpms_defines.vh"

module lpms_top #(
   parameter DUTY = 30,
   parameter COLS = 12
) (
   // Clock and reset
   input  wire        clk,
   input  wire        arst_n,
   input  wire        ce,
   // Host link pins
   input  wire        edge_reset_in,
   input  wire        par_sel,
   input  wire        bus4,
   input  wire        cs_n,
   input  wire        cmd_data_sel,
   input  wire        wr_e,
   input  wire [7:0]  d,
   // Avalon-MM slave
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // Panel drive state
   output reg         display_on,
   output reg         osc_on,
   output reg         booster_on,
   output reg         regulator_on,
   output reg         follower_on,
   output reg  [3:0]  volume,
   output reg  [4:0]  com_sel,
   output reg         sleep_mode,
   output reg         standby_mode
);
   reg  [7:0]  char_display_ram [0:`LPMS_CHARS-1];
   reg  [4:0]  user_char_ram    [0:`LPMS_USER_ROWS-1];
   reg  [4:0]  sym_reg          [0:`LPMS_SYMS-1];
   reg         r1_q;
   reg         r2_q;
   reg         r3_q;
   reg         if_68_q;
   reg         soft_rst_q;
   reg         power_save_on;
   reg  [1:0]  tgt_q;
   reg  [5:0]  adr_q;
   reg  [1:0]  ctrl_q;
   reg  [15:0] cnt_q;
   reg  [15:0] div_q;
   reg  [5:0]  gl_adr_q;
   reg  [2:0]  gl_row_q;
   reg  [4:0]  gl_dots_q;
   reg  [2:0]  gl_st_q;
   reg  [7:0]  gl_code_q;
   reg         ack_q;
   wire        byte_vld;
   wire [7:0]  byte_data;
   wire        byte_is_data;
   wire        req = avs_read | avs_write;
   wire        wr_ok = avs_write & ack_q;

   localparam GL_IDLE = 3'b001;
   localparam GL_CODE = 3'b010;
   localparam GL_DOTS = 3'b100;
   localparam TGT_CHAR = 2'd0;
   localparam TGT_USER = 2'd1;
   localparam TGT_SYM  = 2'd2;

   // Fixed pattern set; this function computes every ROM row.
   function [4:0] rom_row;
      input [7:0] code;
      input [2:0] row;
      begin
         rom_row = code[4:0] ^ {row, row[1:0]};
      end
   endfunction

   // The reset pin is edge sensed, so either edge resets the command
   // state and the new level selects the bus type.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r1_q       <= 1'b0;
         r2_q       <= 1'b0;
         r3_q       <= 1'b0;
         if_68_q    <= 1'b0;
         soft_rst_q <= 1'b0;
      end else if (ce) begin
         r1_q       <= edge_reset_in;
         r2_q       <= r1_q;
         r3_q       <= r2_q;
         soft_rst_q <= r2_q ^ r3_q;
         if (r2_q ^ r3_q)
            if_68_q <= r2_q;
      end
   end

   lpms_link_rx u_rx (
      .clk          (clk),
      .arst_n       (arst_n),
      .ce           (ce & ctrl_q[`LPMS_CTRL_LINK_EN]),
      .soft_rst     (soft_rst_q),
      .if_68        (if_68_q),
      .bus4         (bus4),
      .par_sel      (par_sel),
      .cs_n         (cs_n),
      .cmd_data_sel (cmd_data_sel),
      .wr_e         (wr_e),
      .d            (d),
      .byte_vld     (byte_vld),
      .byte_data    (byte_data),
      .byte_is_data (byte_is_data)
   );

   // Command decode and power state. Each command acts alone, so the
   // display and power save commands work in any order.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         display_on    <= 1'b0;
         power_save_on <= 1'b0;
         osc_on        <= 1'b1;
         booster_on    <= 1'b0;
         regulator_on  <= 1'b0;
         follower_on   <= 1'b0;
         volume        <= 4'h0;
         tgt_q         <= TGT_CHAR;
         adr_q         <= 6'h00;
         cnt_q         <= 16'h0000;
      end else if (ce) begin
         if (soft_rst_q) begin
            display_on    <= 1'b0;
            power_save_on <= 1'b0;
            osc_on        <= 1'b1;
            booster_on    <= 1'b0;
            regulator_on  <= 1'b0;
            follower_on   <= 1'b0;
            volume        <= 4'h0;
            tgt_q         <= TGT_CHAR;
            adr_q         <= 6'h00;
         end else if (byte_vld) begin
            cnt_q <= cnt_q + 16'h0001;
            if (byte_is_data) begin
               adr_q <= adr_q + 6'h01;
            end else if (byte_data[7:6] == `LPMS_OP_SYM_ADR) begin
               tgt_q <= TGT_SYM;
               adr_q <= byte_data[5:0];
            end else if (byte_data[7:5] == `LPMS_OP_USER_ADR) begin
               tgt_q <= TGT_USER;
               adr_q <= {1'b0, byte_data[4:0]};
            end else if (byte_data[7:6] == `LPMS_OP_CHAR_ADR) begin
               tgt_q <= TGT_CHAR;
               adr_q <= byte_data[5:0];
            end else begin
               case (byte_data[7:4])
                  `LPMS_OP_DISP: display_on <= byte_data[0];
                  `LPMS_OP_PSAVE: begin
                     power_save_on <= byte_data[1];
                     osc_on        <= byte_data[0];
                  end
                  `LPMS_OP_PWR: begin
                     booster_on   <= byte_data[2];
                     regulator_on <= byte_data[1];
                     follower_on  <= byte_data[0];
                  end
                  `LPMS_OP_VOL: volume <= byte_data[3:0];
                  default: volume <= volume;
               endcase
            end
         end
      end
   end

   // Memories have no reset; contents stay undefined until written.
   always @(posedge clk) begin
      if (ce && byte_vld && byte_is_data && !soft_rst_q) begin
         case (tgt_q)
            TGT_CHAR: if (adr_q < `LPMS_CHARS) begin
               char_display_ram[adr_q] <= byte_data;
            end
            TGT_USER: begin
               user_char_ram[adr_q[4:0]] <= byte_data[4:0];
            end
            TGT_SYM: if (adr_q < `LPMS_SYMS) begin
               sym_reg[adr_q] <= byte_data[4:0];
            end
            default: ;
         endcase
      end
   end

   // Mode flags and the common scan; the scan stops with the oscillator.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sleep_mode   <= 1'b0;
         standby_mode <= 1'b0;
         div_q        <= 16'h0000;
         com_sel      <= 5'h00;
      end else if (ce) begin
         sleep_mode   <= ~osc_on & ~booster_on;
         standby_mode <= osc_on & ~booster_on & power_save_on;
         if (osc_on && ctrl_q[`LPMS_CTRL_SCAN_EN]) begin
            if (div_q == `LPMS_SCAN_DIV - 16'h0001) begin
               div_q <= 16'h0000;
               if (com_sel == DUTY[4:0] - 5'h01) begin
                  com_sel <= 5'h00;
               end else begin
                  com_sel <= com_sel + 5'h01;
               end
            end else begin
               div_q <= div_q + 16'h0001;
            end
         end
      end
   end

   // Glyph lookup: codes below 4 pick user characters, others the ROM.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gl_st_q   <= GL_IDLE;
         gl_code_q <= 8'h00;
         gl_dots_q <= 5'h00;
      end else if (ce) begin
         case (gl_st_q)
            GL_IDLE: gl_st_q <= GL_IDLE;
            GL_CODE: begin
               gl_code_q <= char_display_ram[gl_adr_q];
               gl_st_q   <= GL_DOTS;
            end
            GL_DOTS: begin
               if (gl_code_q[7:2] == 6'h00) begin
                  gl_dots_q <= user_char_ram[{gl_code_q[1:0], gl_row_q}];
               end else begin
                  gl_dots_q <= rom_row(gl_code_q, gl_row_q);
               end
               gl_st_q <= GL_IDLE;
            end
            default: gl_st_q <= GL_IDLE;
         endcase
         if (wr_ok && avs_address == `LPMS_REG_GLYPH) begin
            gl_st_q <= GL_CODE;
         end
      end
   end

   // Avalon slave: one wait state on every access.
   assign avs_waitrequest = req & ~ack_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_q        <= 1'b0;
         ctrl_q       <= `LPMS_CTRL_RST;
         gl_adr_q     <= 6'h00;
         gl_row_q     <= 3'h0;
         avs_readdata <= 32'h0000_0000;
      end else if (ce) begin
         ack_q <= req & ~ack_q;
         if (wr_ok && avs_address == `LPMS_REG_CTRL)
            ctrl_q <= avs_writedata[1:0];
         if (wr_ok && avs_address == `LPMS_REG_GLYPH) begin
            gl_adr_q <= (avs_writedata[5:0] < `LPMS_CHARS) ?
                        avs_writedata[5:0] : 6'h00;
            gl_row_q <= avs_writedata[10:8];
         end
         if (avs_read && !ack_q) begin
            case (avs_address)
               `LPMS_REG_CTRL:  avs_readdata <= {30'h0, ctrl_q};
               `LPMS_REG_POWER: avs_readdata <= {16'h0, if_68_q,
                  standby_mode, sleep_mode, 1'b0, volume, 2'b0,
                  power_save_on, display_on, osc_on, booster_on,
                  regulator_on, follower_on};
               `LPMS_REG_COUNT: avs_readdata <= {16'h0, cnt_q};
               `LPMS_REG_GLYPH: avs_readdata <= {16'h0, gl_st_q == GL_IDLE,
                  2'b0, gl_dots_q, gl_code_q};
               default:         avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

//--- logic/lpms_defines.vh
`ifndef LPMS_DEFINES_VH
`define LPMS_DEFINES_VH

// Register byte offsets on the Avalon-MM slave.
`define LPMS_REG_CTRL      4'h0
`define LPMS_REG_POWER     4'h4
`define LPMS_REG_COUNT     4'h8
`define LPMS_REG_GLYPH     4'hC

// Control register fields and reset value.
`define LPMS_CTRL_LINK_EN  0
`define LPMS_CTRL_SCAN_EN  1
`define LPMS_CTRL_RST      2'h3

// Command byte opcodes: upper nibble, or upper two or three bits for the address commands.
`define LPMS_OP_DISP       4'h0
`define LPMS_OP_PSAVE      4'h1
`define LPMS_OP_PWR        4'h2
`define LPMS_OP_VOL        4'h3
`define LPMS_OP_CHAR_ADR   2'b01
`define LPMS_OP_USER_ADR   3'b100
`define LPMS_OP_SYM_ADR    2'b11

// Memory sizes.
`define LPMS_CHARS         48
`define LPMS_USER_ROWS     32
`define LPMS_SYMS          48
`define LPMS_BLANK         8'h20

// Scan divider: one common step per this many clocks.
`define LPMS_SCAN_DIV      16'h0400

`endif

//--- logic/lpms_link_rx.v
`timescale 1ns/1ps
`include "lpms_defines.vh"

module lpms_link_rx (
   // Clock and reset
   input  wire       clk,
   input  wire       arst_n,
   input  wire       ce,
   input  wire       soft_rst,
   // Mode selects
   input  wire       if_68,
   input  wire       bus4,
   // Pins
   input  wire       par_sel,
   input  wire       cs_n,
   input  wire       cmd_data_sel,
   input  wire       wr_e,
   input  wire [7:0] d,
   // Received bytes
   output reg        byte_vld,
   output reg  [7:0] byte_data,
   output reg        byte_is_data
);
   reg  [11:0] s1_q;
   reg  [11:0] s2_q;
   reg  [11:0] s3_q;
   reg  [7:0]  sh_q;
   reg  [2:0]  bit_q;
   reg         nib_q;
   reg  [3:0]  hi_q;
   wire        par   = s2_q[11];
   wire        csn   = s2_q[10];
   wire        a0    = s2_q[9];
   wire        strb  = s2_q[8];
   wire        strb3 = s3_q[8];
   wire [7:0]  dat   = s2_q[7:0];
   // 80-style takes data on rising WR; 68-style on falling E.
   wire        take  = if_68 ? (strb3 & ~strb) : (~strb3 & strb);
   wire        sclk_rise = ~s3_q[6] & s2_q[6];

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= 12'h000;
         s2_q <= 12'h000;
         s3_q <= 12'h000;
      end else if (ce) begin
         s1_q <= {par_sel, cs_n, cmd_data_sel, wr_e, d};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sh_q         <= 8'h00;
         bit_q        <= 3'h0;
         nib_q        <= 1'b0;
         hi_q         <= 4'h0;
         byte_vld     <= 1'b0;
         byte_data    <= 8'h00;
         byte_is_data <= 1'b0;
      end else if (ce) begin
         byte_vld <= 1'b0;
         if (soft_rst) begin
            bit_q <= 3'h0;
            nib_q <= 1'b0;
         end else if (!par) begin
            // Serial: top pin is data, next pin is clock, rest unused.
            if (csn) begin
               bit_q <= 3'h0;
            end else if (sclk_rise) begin
               sh_q  <= {sh_q[6:0], dat[7]};
               bit_q <= bit_q + 3'h1;
               if (bit_q == 3'h7) begin
                  byte_vld     <= 1'b1;
                  byte_data    <= {sh_q[6:0], dat[7]};
                  byte_is_data <= a0;
               end
            end
         end else if (!csn && take) begin
            if (bus4) begin
               // Four-bit bus: high nibble first on the upper pins.
               nib_q <= ~nib_q;
               hi_q  <= dat[7:4];
               if (nib_q) begin
                  byte_vld     <= 1'b1;
                  byte_data    <= {hi_q, dat[7:4]};
                  byte_is_data <= a0;
               end
            end else begin
               byte_vld     <= 1'b1;
               byte_data    <= dat;
               byte_is_data <= a0;
            end
         end
      end
   end
endmodule

//--- verif/lpms_top_chk.sv
`timescale 1ns/1ps
module lpms_top_chk #(
   parameter DUTY = 30
) (
   // Clock and reset
   input logic        clk,
   input logic        arst_n,
   input logic        ce,
   input logic        edge_reset_in,
   // Register bus
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest,
   // Panel state
   input logic        display_on,
   input logic        osc_on,
   input logic        booster_on,
   input logic [3:0]  volume,
   input logic [4:0]  com_sel,
   input logic        sleep_mode,
   input logic        standby_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   chk_sleep_lvl: assert property (
      ce |=> sleep_mode == $past(!osc_on && !booster_on))
      else $error("sleep flag disagrees with power bits");
   chk_standby_cond: assert property (
      standby_mode |-> $past(osc_on && !booster_on))
      else $error("standby flag without running oscillator");
   chk_mode_excl: assert property (
      !(sleep_mode && standby_mode))
      else $error("sleep and standby together");
   chk_one_wait: assert property (
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one wait state");
   chk_rdata_hold: assert property (
      !avs_read |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   chk_com_range: assert property (
      com_sel < DUTY)
      else $error("common index beyond duty");
   chk_com_step: assert property (
      $changed(com_sel) |->
      com_sel == 5'h00 || com_sel == $past(com_sel) + 5'h01)
      else $error("common index skipped");
   chk_pin_reset: assert property (
      $changed(edge_reset_in) |-> ##[1:10]
      (osc_on && !booster_on && !display_on && volume == 4'h0))
      else $error("edge reset did not restore power state");
   chk_ce_freeze: assert property (
      !ce |=> $stable(volume) && $stable(com_sel) && $stable(osc_on))
      else $error("state moved while clock enable low");
   cover property ($rose(sleep_mode));
   cover property ($rose(standby_mode));
   cover property (avs_read && !avs_waitrequest);
endmodule

bind lpms_top lpms_top_chk #(.DUTY(DUTY)) u_chk (
   .clk(clk), .arst_n(arst_n), .ce(ce), .edge_reset_in(edge_reset_in),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .display_on(display_on),
   .osc_on(osc_on), .booster_on(booster_on), .volume(volume),
   .com_sel(com_sel), .sleep_mode(sleep_mode), .standby_mode(standby_mode));

//--- verif/lpms_host_model.sv
`timescale 1ns/1ps
module lpms_host_model #(
   parameter WAIT_CYC = 64
) (
   // Clock
   input  wire        clk,
   // Link pins
   output logic       cs_n = 1'b1,
   output logic       cmd_data_sel = 1'b0,
   output logic       wr_e = 1'b1,
   output logic [7:0] d = 8'h00,
   output logic       par_sel = 1'b1,
   output logic       bus4 = 1'b0,
   output logic       edge_reset_in = 1'b0
);
   task automatic hold(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // The strobe idles high for 80-style and low for 68-style buses.
   task automatic strobe(input [7:0] v);
      begin
         d <= v;
         hold(2);
         wr_e <= edge_reset_in;
         hold(4);
         wr_e <= !edge_reset_in;
         hold(4);
      end
   endtask
   task automatic set_mode(input p, input b4, input i68);
      begin
         par_sel <= p;
         bus4 <= b4;
         edge_reset_in <= i68;
         wr_e <= !i68;
         d <= 8'h00;
         hold(12);
      end
   endtask
   task automatic send(input cd, input [7:0] b);
      integer i;
      begin
         cs_n <= 1'b0;
         cmd_data_sel <= cd;
         if (!par_sel) begin
            for (i = 7; i >= 0; i--) begin
               d <= {b[i], 7'h00};
               hold(4);
               d[6] <= 1'b1;
               hold(4);
            end
         end else if (bus4) begin
            strobe({b[7:4], 4'h0});
            strobe({b[3:0], 4'h0});
         end else begin
            strobe(b);
         end
         // Released data lines show the inverse so stale bits are not read.
         cs_n <= 1'b1;
         d <= ~d;
         hold(8);
      end
   endtask
   task automatic settle;
      hold(WAIT_CYC);
   endtask
   task automatic init_seq(input [3:0] v);
      begin
         settle();
         send(1'b0, 8'h27);
         send(1'b0, {4'h3, v});
      end
   endtask
   task automatic ram_clear;
      integer i;
      begin
         send(1'b0, 8'h40);
         for (i = 0; i < 48; i++) send(1'b1, 8'h20);
         send(1'b0, 8'h80);
         for (i = 0; i < 32; i++) send(1'b1, 8'h00);
         send(1'b0, 8'hC0);
         for (i = 0; i < 48; i++) send(1'b1, 8'h00);
      end
   endtask
   task automatic low_seq(input disp_first, input osc);
      begin
         if (disp_first) send(1'b0, 8'h00);
         send(1'b0, {7'h09, osc});
         if (!disp_first) send(1'b0, 8'h00);
         send(1'b0, 8'h20);
      end
   endtask
   task automatic wake_seq(input disp_first, input [3:0] v);
      begin
         if (disp_first) send(1'b0, 8'h01);
         send(1'b0, 8'h11);
         if (!disp_first) send(1'b0, 8'h01);
         settle();
         send(1'b0, 8'h30);
         send(1'b0, 8'h27);
         send(1'b0, {4'h3, v});
      end
   endtask
endmodule

//--- verif/lpms_top_tb.sv
`timescale 1ns/1ps
`include "lpms_defines.vh"
module lpms_top_tb;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        ce = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata, ee, em;
   logic        avs_waitrequest, cs_n, cmd_data_sel, wr_e, par_sel, bus4;
   logic        edge_reset_in, display_on, osc_on, booster_on;
   logic        regulator_on, follower_on, sleep_mode, standby_mode;
   logic [7:0]  d, r;
   logic [3:0]  volume, v;
   logic [4:0]  com_sel;
   logic [31:0] exp_q[$], msk_q[$];
   logic        if68 = 1'b0;
   integer      error_cnt = 0;
   integer      n_tests = 0;
   always #4 clk = ~clk;
   lpms_top #(.DUTY(16)) dut (
      .clk(clk), .arst_n(arst_n), .ce(ce), .edge_reset_in(edge_reset_in),
      .par_sel(par_sel), .bus4(bus4), .cs_n(cs_n), .wr_e(wr_e), .d(d),
      .cmd_data_sel(cmd_data_sel), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .display_on(display_on),
      .osc_on(osc_on), .booster_on(booster_on), .volume(volume),
      .regulator_on(regulator_on), .follower_on(follower_on),
      .com_sel(com_sel), .sleep_mode(sleep_mode), .standby_mode(standby_mode));
   lpms_host_model host (
      .clk(clk), .cs_n(cs_n), .cmd_data_sel(cmd_data_sel), .wr_e(wr_e),
      .d(d), .par_sel(par_sel), .bus4(bus4), .edge_reset_in(edge_reset_in));
   task automatic tally_and_finish;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
         if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task automatic compare(input string nm, input [31:0] e, input [31:0] g);
      begin
         n_tests++;
         if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // A mask of zero marks a read whose data is not judged.
   task automatic av(input rw, input [3:0] a, input [31:0] wd,
                     input [31:0] e, input [31:0] m);
      integer n;
      begin
         if (!rw) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
         end
         @(posedge clk);
         avs_address <= a;
         avs_writedata <= wd;
         avs_write <= rw;
         avs_read <= !rw;
         n = 0;
         // Waitrequest is judged at the rising edge that accepts the request.
         do begin
            @(posedge clk);
            n++;
         end while (avs_waitrequest !== 1'b0 && n < 50);
         if (n >= 50) begin
            error_cnt++;
            tally_and_finish();
         end
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask
   always @(posedge clk)
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         em = msk_q.pop_front();
         ee = exp_q.pop_front();
         if (em != 32'h0) compare("readdata", ee & em, avs_readdata & em);
      end
   // Bits: power save, display, oscillator, booster, regulator, follower.
   task automatic state_is(input [5:0] b, input [3:0] vol);
      logic sl, sb;
      begin
         sl = !b[3] && !b[2];
         sb = b[3] && !b[2] && b[5];
         repeat (4) @(posedge clk);
         compare("panel", {b[4:0], vol, sl, sb}, {display_on, osc_on,
            booster_on, regulator_on, follower_on, volume, sleep_mode,
            standby_mode});
         av(1'b0, `LPMS_REG_POWER, 0, {if68, sb, sl, 1'b0, vol, 2'b00, b},
            32'h0000_EF3F);
      end
   endtask
   task automatic glyph(input [5:0] i, input [7:0] c);
      begin
         av(1'b1, `LPMS_REG_GLYPH, {26'h0, i}, 0, 0);
         av(1'b0, `LPMS_REG_GLYPH, 0, 0, 0);
         av(1'b0, `LPMS_REG_GLYPH, 0, {24'h80, c}, 32'h0000_80FF);
      end
   endtask
   initial begin
      r = 8'($urandom(32'h113B));
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      av(1'b0, `LPMS_REG_CTRL, 0, `LPMS_CTRL_RST, 32'h0000_0003);
      av(1'b1, 4'h2, 32'hFFFF_FFFF, 0, 0);
      av(1'b0, 4'h2, 0, 0, 32'hFFFF_FFFF);
      av(1'b1, `LPMS_REG_POWER, 32'hFFFF_FFFF, 0, 0);
      state_is(6'h08, 4'h0);
      host.ram_clear();
      glyph(6'h2F, 8'h20);
      v = 4'($urandom_range(15, 1));
      host.init_seq(v);
      state_is(6'h0F, v);
      host.send(1'b0, 8'h01);
      host.low_seq(1'b1, 1'b0);
      state_is(6'h20, v);
      host.wake_seq(1'b0, v);
      state_is(6'h1F, v);
      host.low_seq(1'b0, 1'b1);
      state_is(6'h28, v);
      host.wake_seq(1'b1, v);
      state_is(6'h1F, v);
      for (int m = 0; m < 4; m++) begin
         if68 = (m == 2);
         host.set_mode(m != 3, m == 1, m == 2);
         v = 4'($urandom_range(15, 1));
         host.send(1'b0, {4'h3, v});
         host.send(1'b1, {4'h3, ~v});
         state_is((m < 2) ? 6'h1F : 6'h08, v);
      end
      host.set_mode(1'b1, 1'b0, 1'b0);
      av(1'b1, `LPMS_REG_CTRL, 32'h0000_0002, 0, 0);
      host.send(1'b0, 8'h27);
      state_is(6'h08, v);
      av(1'b1, `LPMS_REG_CTRL, `LPMS_CTRL_RST, 0, 0);
      r = 8'($urandom);
      host.send(1'b0, 8'h47);
      host.send(1'b1, r);
      if68 = 1'b1;
      host.set_mode(1'b1, 1'b0, 1'b1);
      glyph(6'h07, r);
      av(1'b0, `LPMS_REG_COUNT, 0, 32'h0000_00A0, 32'h0000_FFFF);
      ce <= 1'b0;
      repeat (6) @(posedge clk);
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      tally_and_finish();
   end
endmodule
